// ### rtl/umd_pkg.sv
package umd_pkg;

    // ------------------------------------------------------------
    // line function and flow scheme encodings
    // ------------------------------------------------------------
    localparam logic [2:0] LFS_RS485    = 3'h3;
    localparam int         LFS_POL_BIT  = 3;
    localparam logic [2:0] FLOW_MD_RX   = 3'h3;
    localparam logic [2:0] FLOW_MD_TX   = 3'h4;
    localparam int         FLOW_HDX_BIT = 3;

    // ------------------------------------------------------------
    // character format
    // ------------------------------------------------------------
    localparam logic [1:0] DLEN_7   = 2'h0;
    localparam logic [1:0] DLEN_8   = 2'h1;
    localparam logic [1:0] DLEN_9   = 2'h2;
    localparam int         CHAR_W   = 9;
    localparam int         BYTE_W   = 8;
    localparam int         TX_DEPTH = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ      = 100_000_000;
    localparam int          BAUD_DEF    = 9600;
    localparam logic [15:0] BIT_CYC_DEF = 16'(CLK_HZ / BAUD_DEF);
    localparam logic [3:0]  TURN_MAX    = 4'hf;

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_LEAD  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b011,
        TX_PAR   = 3'b100,
        TX_STOP  = 3'b101
    } umd_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } umd_rx_state_t;

endpackage

// ### rtl/umd_fifo_if.sv
`timescale 1ns/1ns
interface umd_fifo_if #(parameter int W = 9);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;

    modport fifo (
        input  in_data,
        input  in_valid,
        output in_ready,
        output out_data,
        output out_valid,
        input  out_ready
    );
    modport user (
        output in_data,
        output in_valid,
        input  in_ready,
        input  out_data,
        input  out_valid,
        output out_ready
    );
endinterface

// ### rtl/umd_fifo.sv
`timescale 1ns/1ns
module umd_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    umd_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          empty = (wr_q == rd_q);
    wire          full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) &&
                          (wr_q[AW] != rd_q[AW]);
    wire          push  = f.in_valid && !full;
    wire          pop   = f.out_ready && !empty;

    assign f.in_ready  = !full;
    assign f.out_valid = !empty;
    assign f.out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= f.in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

// ### rtl/umd_line_ctrl.sv
// Contract
// - rs485 pin function only when selected
// - driver enable asserted before first start bit
// - zero delay: release right after stop bit
// - select bit 3 inverts enable polarity
// - release delayed by 1 to 15 bit times
// - flow schemes 3 and 4 mean multidrop
// - compare address bytes to both addresses
// - ninth or parity bit set marks address
// - match enables receiver, data bytes stored
// - mismatched address disables receiver
// - scheme 3 keeps transmitter always enabled
// - scheme 4 transmits only while matched
// - flow bit 3 selects half duplex
// - half duplex drops receive while sending
// - start, data lsb first, parity, stops
// - store low eight bits, drop the rest
`timescale 1ns/1ns
module umd_line_ctrl #(
    parameter int DEPTH = umd_pkg::TX_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  line_function_select,
    input  wire logic [3:0]  flow_scheme_select,
    input  wire logic [3:0]  turnaround_delay,
    input  wire logic [7:0]  unicast_addr_match,
    input  wire logic [7:0]  multicast_addr_match,
    input  wire logic [1:0]  data_len,
    input  wire logic        parity_en,
    input  wire logic        parity_odd,
    input  wire logic        two_stop,
    input  wire logic [15:0] bit_cycles,
    input  wire logic [8:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic             rx_matched,
    output logic             txd,
    input  wire logic        rxd,
    output logic             direction_enable_pin
);
    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    wire rs485_sel = line_function_select[2:0] == umd_pkg::LFS_RS485;
    wire de_pol    = line_function_select[umd_pkg::LFS_POL_BIT];
    wire md4       = flow_scheme_select[2:0] == umd_pkg::FLOW_MD_TX;
    wire md_on     = md4 ||
                     flow_scheme_select[2:0] == umd_pkg::FLOW_MD_RX;
    wire hdx       = flow_scheme_select[umd_pkg::FLOW_HDX_BIT];
    wire [3:0] n_bits = (data_len == umd_pkg::DLEN_7) ? 4'h7 :
                        (data_len == umd_pkg::DLEN_8) ? 4'h8 : 4'h9;
    wire [15:0] bit_last  = bit_cycles - 16'h1;
    wire [15:0] half_last = {1'b0, bit_cycles[15:1]};

    logic match_q;

    // ------------------------------------------------------------
    // transmit fifo
    // ------------------------------------------------------------
    umd_fifo_if #(.W(umd_pkg::CHAR_W)) txf ();

    umd_fifo #(
        .W     (umd_pkg::CHAR_W),
        .DEPTH (DEPTH)
    ) u_txf (
        .clk     (clk),
        .sys_rst (sys_rst),
        .f       (txf)
    );

    assign txf.in_data  = tx_data;
    assign txf.in_valid = tx_valid;
    assign tx_ready     = txf.in_ready;

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    umd_pkg::umd_tx_state_t tx_st_q;
    umd_pkg::umd_tx_state_t tx_st_d;
    logic [8:0]  tx_sh_q;
    logic [3:0]  tx_bit_q;
    logic [15:0] tx_cyc_q;
    logic        tx_par_q;
    logic        tx_stop2_q;
    logic [3:0]  hold_q;
    logic        txd_q;
    logic        de_on_q;

    // gating in scheme 4 stalls the fifo drain, so back-pressure
    // reaches tx_ready once the eight words are taken
    wire tx_en    = !md4 || match_q;
    wire tx_busy  = tx_st_q != umd_pkg::TX_IDLE;
    wire tx_load  = !tx_busy && txf.out_valid && tx_en;
    wire tx_tick  = tx_cyc_q == bit_last;
    wire stop_end = tx_st_q == umd_pkg::TX_STOP && tx_tick &&
                    !(two_stop && !tx_stop2_q);
    wire last_bit = tx_bit_q == n_bits - 4'h1;
    wire [8:0] tx_mask = (data_len == umd_pkg::DLEN_7) ? 9'h07f :
                         (data_len == umd_pkg::DLEN_8) ? 9'h0ff : 9'h1ff;
    // a word popped right after a stop bit keeps the enable up,
    // so the pin never blinks off between back-to-back characters
    wire de_act   = tx_busy || hold_q != 4'h0 || tx_load;
    assign txf.out_ready = tx_load;

    always_comb begin
        tx_st_d = tx_st_q;
        case (tx_st_q)
            umd_pkg::TX_IDLE:  if (tx_load) tx_st_d = umd_pkg::TX_LEAD;
            umd_pkg::TX_LEAD:  tx_st_d = umd_pkg::TX_START;
            umd_pkg::TX_START: if (tx_tick) tx_st_d = umd_pkg::TX_DATA;
            umd_pkg::TX_DATA: begin
                if (tx_tick && last_bit) begin
                    tx_st_d = parity_en ? umd_pkg::TX_PAR
                                        : umd_pkg::TX_STOP;
                end
            end
            umd_pkg::TX_PAR:   if (tx_tick) tx_st_d = umd_pkg::TX_STOP;
            umd_pkg::TX_STOP:  if (stop_end) tx_st_d = umd_pkg::TX_IDLE;
            default:           tx_st_d = umd_pkg::TX_IDLE;
        endcase
    end

    // line level follows the frame order start, data, parity, stop
    wire txd_d = (tx_st_q == umd_pkg::TX_START) ? 1'b0 :
                 (tx_st_q == umd_pkg::TX_DATA)  ? tx_sh_q[0] :
                 (tx_st_q == umd_pkg::TX_PAR)   ? tx_par_q : 1'b1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_q <= umd_pkg::TX_IDLE;
            txd_q   <= 1'b1;
            de_on_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            txd_q   <= txd_d;
            de_on_q <= de_act;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sh_q <= '0;
            tx_par_q <= 1'b0;
            tx_bit_q <= '0;
            tx_stop2_q <= 1'b0;
        end else if (tx_load) begin
            tx_sh_q    <= txf.out_data & tx_mask;
            tx_par_q   <= ^(txf.out_data & tx_mask) ^ parity_odd;
            tx_bit_q   <= '0;
            tx_stop2_q <= 1'b0;
        end else if (tx_tick && tx_st_q == umd_pkg::TX_DATA) begin
            tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
        end else if (tx_tick && tx_st_q == umd_pkg::TX_STOP) begin
            tx_stop2_q <= 1'b1;
        end
    end

    // bit-time counter also paces the turnaround hold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cyc_q <= '0;
        end else if (!de_act || tx_tick || tx_st_q == umd_pkg::TX_LEAD) begin
            tx_cyc_q <= '0;
        end else begin
            tx_cyc_q <= tx_cyc_q + 16'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= '0;
        end else if (tx_load) begin
            hold_q <= '0;
        end else if (stop_end) begin
            hold_q <= turnaround_delay;
        end else if (!tx_busy && hold_q != 4'h0 && tx_tick) begin
            hold_q <= hold_q - 4'h1;
        end
    end

    assign txd = txd_q;
    // outside rs485 function the pin rests at its inactive level
    assign direction_enable_pin = (rs485_sel && de_on_q) ^ de_pol;
    // polarity select flips the level on the pin

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    umd_pkg::umd_rx_state_t rx_st_q;
    logic        rx_s1_q;
    logic        rx_s2_q;
    logic [15:0] rx_cyc_q;
    logic [3:0]  rx_bit_q;
    logic [8:0]  rx_sh_q;
    logic        rx_pbit_q;
    logic [7:0]  rx_data_q;
    logic        rx_valid_q;
    logic        md_prev_q;

    // own transmission would echo back on a shared pair
    wire rx_gate  = hdx && tx_busy;
    wire rx_tick  = rx_cyc_q == ((rx_st_q == umd_pkg::RX_START) ?
                                 half_last : bit_last);
    wire rx_done  = rx_st_q == umd_pkg::RX_STOP && rx_tick;
    wire is_addr  = (data_len == umd_pkg::DLEN_9) ? rx_sh_q[8] :
                    rx_pbit_q;
    wire addr_hit = rx_sh_q[7:0] == unicast_addr_match ||
                    rx_sh_q[7:0] == multicast_addr_match;
    wire rx_store = rx_done && !rx_gate &&
                    (!md_on || (!is_addr && match_q));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= rxd;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_q  <= umd_pkg::RX_IDLE;
            rx_cyc_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q  <= '0;
            rx_pbit_q <= 1'b0;
        end else if (rx_gate) begin
            rx_st_q  <= umd_pkg::RX_IDLE;
            rx_cyc_q <= '0;
        end else begin
            rx_cyc_q <= (rx_tick || rx_st_q == umd_pkg::RX_IDLE) ?
                        16'h0 : rx_cyc_q + 16'h1;
            case (rx_st_q)
                umd_pkg::RX_IDLE: begin
                    if (!rx_s2_q) begin
                        rx_st_q  <= umd_pkg::RX_START;
                        rx_sh_q  <= '0;
                        rx_bit_q <= '0;
                        rx_pbit_q <= 1'b0;
                    end
                end
                umd_pkg::RX_START: begin
                    if (rx_tick) begin
                        rx_st_q <= rx_s2_q ? umd_pkg::RX_IDLE
                                           : umd_pkg::RX_DATA;
                    end
                end
                umd_pkg::RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q[rx_bit_q] <= rx_s2_q;
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == n_bits - 4'h1) begin
                            rx_st_q <= parity_en ? umd_pkg::RX_PAR
                                                 : umd_pkg::RX_STOP;
                        end
                    end
                end
                umd_pkg::RX_PAR: begin
                    if (rx_tick) begin
                        rx_pbit_q <= rx_s2_q;
                        rx_st_q   <= umd_pkg::RX_STOP;
                    end
                end
                umd_pkg::RX_STOP: if (rx_tick) rx_st_q <= umd_pkg::RX_IDLE;
                default:          rx_st_q <= umd_pkg::RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // multidrop match and receive holding word
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            md_prev_q <= 1'b0;
            match_q   <= 1'b0;
        end else begin
            md_prev_q <= md_on;
            if (md_on && !md_prev_q) begin
                match_q <= 1'b0;
            end else if (rx_done && !rx_gate && md_on && is_addr) begin
                match_q <= addr_hit;
            end
        end
    end

    // framing and parity outcomes are not kept, only the low byte;
    // a word not yet taken is overwritten by the next one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_data_q  <= '0;
            rx_valid_q <= 1'b0;
        end else begin
            if (rx_store) begin
                rx_data_q <= rx_sh_q[7:0];
            end
            rx_valid_q <= rx_store || (rx_valid_q && !rx_ready);
        end
    end

    assign rx_data    = rx_data_q;
    assign rx_valid   = rx_valid_q;
    assign rx_matched = match_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DE_IDLE_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
        !rs485_sel |-> direction_enable_pin == de_pol)
        else $error("enable pin active without rs485 function");
    AST_DE_POLARITY: assert property (@(posedge clk) disable iff (sys_rst)
        rs485_sel && de_on_q |-> direction_enable_pin == !de_pol)
        else $error("enable pin polarity wrong");
    AST_DE_BEFORE_START: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(txd_q) |-> $past(de_on_q))
        else $error("start bit sent without driver enable");
    AST_DE_ZERO_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
        stop_end && turnaround_delay == 4'h0 ##1 !tx_load
        |=> !de_on_q)
        else $error("enable not released after last stop bit");
    AST_TURN_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        stop_end |=> hold_q == $past(turnaround_delay))
        else $error("turnaround count not loaded");
    AST_MD_HIT: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done && !rx_gate && md_on && is_addr && addr_hit
        && !(md_on && !md_prev_q) |=> match_q)
        else $error("matching address did not enable receiver");
    AST_MD_MISS: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done && !rx_gate && md_on && is_addr && !addr_hit
        |=> !match_q ##1 !rx_valid_q || $past(rx_valid_q))
        else $error("mismatched address left receiver enabled");
    AST_MD_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
        md_on && !md_prev_q |=> !match_q)
        else $error("multidrop entry did not clear match");
    AST_MODE4_TX: assert property (@(posedge clk) disable iff (sys_rst)
        md4 && !match_q |-> !txf.out_ready)
        else $error("scheme 4 sent without address match");
    AST_HDX_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        hdx && tx_busy |=> !rx_valid_q || $past(rx_valid_q))
        else $error("receive data taken while sending in half duplex");
endmodule

// ### tb/umd_remote_node.sv
`timescale 1ns/1ns
module umd_remote_node #(
    parameter int BIT = 4,
    parameter int NB  = 9
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd,
    input  wire logic dep
);
    // ----------
    // remote node: sends on rxd, decodes txd
    // ----------
    logic [8:0] got_q[$];
    logic       pin_q[$];
    time        last_start;
    logic [8:0] sh;

    // marking level between frames, as the line bias holds it
    initial rxd = 1'b1;

    task automatic send(input logic [8:0] v);
        @(negedge clk);
        rxd = 1'b0;
        repeat (BIT) @(negedge clk);
        for (int i = 0; i < NB; i++) begin
            rxd = v[i];
            repeat (BIT) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (BIT) @(negedge clk);
    endtask

    // mid-bit sampling; the enable pin is noted at mid start
    always begin
        @(negedge txd);
        last_start = $time;
        repeat (BIT / 2) @(posedge clk);
        pin_q.push_back(dep);
        for (int i = 0; i < NB; i++) begin
            repeat (BIT) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        got_q.push_back(sh);
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    // ----------
    // wiring
    // ----------
    localparam int BIT = 4;
    logic       clk;
    logic       sys_rst;
    logic [3:0] lfs;
    logic [3:0] fss;
    logic [3:0] tdly;
    logic [7:0] uni;
    logic [7:0] multi;
    logic [8:0] tx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_ready;
    logic       rx_matched;
    logic       txd;
    logic       rxd;
    logic       dep;
    logic [1:0] dlen;
    logic       pen;
    logic [7:0] rx_q[$];
    int         err_total;
    int         samples_checked;
    int         lo;
    int         n;
    logic [3:0] dly_tab[4] = '{4'h0, 4'h1, 4'hf, 4'h0};
    logic       pol_tab[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    umd_line_ctrl i_umd_line_ctrl (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .line_function_select (lfs),
        .flow_scheme_select   (fss),
        .turnaround_delay     (tdly),
        .unicast_addr_match   (uni),
        .multicast_addr_match (multi),
        .data_len             (dlen),
        .parity_en            (pen),
        .parity_odd           (1'b0),
        .two_stop             (1'b0),
        .bit_cycles           (16'h0004),
        .tx_data              (tx_data),
        .tx_valid             (tx_valid),
        .tx_ready             (tx_ready),
        .rx_data              (rx_data),
        .rx_valid             (rx_valid),
        .rx_ready             (rx_ready),
        .rx_matched           (rx_matched),
        .txd                  (txd),
        .rxd                  (rxd),
        .direction_enable_pin (dep)
    );

    umd_remote_node #(.BIT(BIT), .NB(9)) i_umd_remote_node (
        .clk (clk),
        .txd (txd),
        .rxd (rxd),
        .dep (dep)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rx_q.push_back(rx_data);
    end

    // ----------
    // tasks
    // ----------
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int l, input int g);
        samples_checked++;
        if (g < l || g > l + BIT) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, l, l+BIT, g);
        end
    endtask

    // holds valid until a falling edge shows ready, so the next rise takes it
    task automatic push(input logic [8:0] v);
        @(negedge clk);
        tx_data  = v;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    task automatic wait_dep(input logic v);
        n = 0;
        while (dep !== v && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("dep_level", 9'(v), 9'(dep));
    endtask

    task automatic wait_frames(input int k);
        n = 0;
        while (i_umd_remote_node.got_q.size() < k && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("frames", 9'(k), 9'(i_umd_remote_node.got_q.size()));
    endtask

    task automatic rx_send(input logic [8:0] v);
        i_umd_remote_node.send(v);
        repeat (3 * BIT) @(negedge clk);
    endtask

    task automatic clean(input string nm);
        i_umd_remote_node.got_q.delete();
        i_umd_remote_node.pin_q.delete();
        rx_q.delete();
        $display("test %s done", nm);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------
    // tests
    // ----------
    initial begin
        {lfs, fss, tdly, tx_data, tx_valid} = '0;
        lfs = 4'h3;
        uni = 8'h21;
        multi = 8'h7e;
        rx_ready = 1'b1;
        dlen = 2'h2;
        pen = 1'b0;
        err_total = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        chk("rst", 9'h00c, {5'h0, txd, tx_ready, rx_valid, rx_matched});
        chk("rst_dep", 9'h0, 9'(dep));
        for (int k = 0; k < 4; k++) begin
            lfs  = {pol_tab[k], 3'h3};
            tdly = dly_tab[k];
            @(negedge clk);
            chk("dep_idle", 9'(pol_tab[k]), 9'(dep));
            push(9'h0a5);
            wait_dep(~pol_tab[k]);
            chk("txd_lead", 9'h1, 9'(txd));
            push(9'h05a);
            wait_dep(pol_tab[k]);
            lo = int'(($time - i_umd_remote_node.last_start) / 10);
            chk_rng("release", (11 + int'(dly_tab[k])) * BIT, lo);
            wait_frames(2);
            chk("char0", 9'h0a5, i_umd_remote_node.got_q[0]);
            chk("char1", 9'h05a, i_umd_remote_node.got_q[1]);
            chk("pin_mid", {7'h0, {2{~pol_tab[k]}}},
                {7'h0, i_umd_remote_node.pin_q[0],
                 i_umd_remote_node.pin_q[1]});
            clean("turnaround");
        end
        for (int k = 0; k < 2; k++) begin
            lfs = {1'b0, k[0], 2'h0};
            push(9'h033);
            wait_frames(1);
            chk("pin_off", 9'h0, 9'(i_umd_remote_node.pin_q[0]));
            clean("function_select");
        end
        lfs = 4'h3;
        fss = 4'h3;
        rx_send(9'h05a);
        chk("pre_match", 9'h0, {rx_matched, 8'(rx_q.size())});
        rx_send({1'b1, uni});
        chk("uni", 9'h100, {rx_matched, 8'(rx_q.size())});
        rx_send(9'h0c3);
        chk("data_on", 9'h0c3, 9'(rx_q.pop_front()));
        rx_send(9'h155);
        rx_send(9'h011);
        chk("other", 9'h0, {rx_matched, 8'(rx_q.size())});
        push(9'h077);
        wait_frames(1);
        chk("tx_md3", 9'h077, i_umd_remote_node.got_q[0]);
        rx_send({1'b1, multi});
        rx_send(9'h03c);
        chk("multi", 9'h13c, {rx_matched, rx_q.pop_front()});
        clean("multidrop_rx");
        fss = 4'h0;
        @(negedge clk);
        fss = 4'h4;
        @(negedge clk);
        chk("md4_entry", 9'h0, 9'(rx_matched));
        for (int k = 0; k < 8; k++)
            push(9'(k + 1));
        chk("full", 9'h0, 9'(tx_ready));
        @(negedge clk);
        tx_data  = 9'h0ee;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
        repeat (20 * BIT) @(negedge clk);
        chk("held", 9'h0, 9'(i_umd_remote_node.got_q.size()));
        rx_send({1'b1, uni});
        wait_frames(8);
        repeat (15 * BIT) @(negedge clk);
        chk("drained", 9'h108, {tx_ready,
            8'(i_umd_remote_node.got_q.size())});
        for (int k = 0; k < 8; k++)
            chk("order", 9'(k + 1), i_umd_remote_node.got_q[k]);
        clean("multidrop_tx");
        for (int k = 0; k < 2; k++) begin
            fss = {~k[0], 3'h0};
            push(9'h0f0);
            n = 0;
            while (txd !== 1'b0 && n < 100) begin
                @(negedge clk);
                n++;
            end
            rx_send(9'h1c3);
            chk("hdx_rx", {k[0], 8'(k * 8'hc3)},
                {rx_q.size() > 0,
                 (rx_q.size() > 0) ? rx_q[0] : 8'h00});
            wait_frames(1);
            clean("half_duplex");
        end
        rx_send(9'h1a5);
        chk("low8", 9'h0a5, 9'(rx_q.pop_front()));
        clean("nine_bit");
        dlen = 2'h1;
        pen  = 1'b1;
        fss  = 4'h3;
        rx_send({1'b1, multi});
        rx_send(9'h066);
        chk("par_addr", 9'h166, {rx_matched, rx_q.pop_front()});
        clean("parity_addr");
        close_out();
    end

    initial begin
        #300000;
        err_total++;
        close_out();
    end
endmodule
